//--- hdl/blr_pkg.sv
package blr_pkg;

   // Register byte offsets on the Avalon-MM slave
   localparam logic [4:0] REG_CMD = 5'h00;
   localparam logic [4:0] REG_STATUS = 5'h04;
   localparam logic [4:0] REG_ACC_ONE = 5'h08;
   localparam logic [4:0] REG_ACC_TWO = 5'h0C;
   localparam logic [4:0] REG_CTRL = 5'h10;

   // Command word field positions
   localparam int CMD_OP_LSB = 0;
   localparam int CMD_OP_W = 5;
   localparam int CMD_AREA_LSB = 8;
   localparam int CMD_AREA_W = 3;
   localparam int CMD_INDEX_LSB = 16;
   localparam int CMD_INDEX_W = 16;

   // Status register extra field positions
   localparam int STAT_DEPTH_LSB = 16;
   localparam int STAT_OVF_BIT = 24;
   localparam int STAT_UNF_BIT = 25;

   // Control register field positions
   localparam int CTRL_GATE_BIT = 0;

   // Widths and depths
   localparam int ACC_W = 16;
   localparam int STACK_DEPTH = 7;
   localparam int DEPTH_W = 3;

   // Values after reset
   localparam logic [8:0] STATUS_RESET = 9'h000;
   localparam logic [31:0] CMD_RESET = 32'h0000_0000;
   localparam logic [15:0] ACC_RESET = 16'h0000;
   localparam logic GATE_RESET = 1'b1;

   // Bit memory areas
   typedef enum logic [2:0] {
      AREA_INPUT, AREA_OUTPUT, AREA_MARKER, AREA_LOCAL, AREA_DATA
   } blr_area_type;

   // Instruction codes, in declaration order from zero
   typedef enum logic [4:0] {
      OP_NOP, OP_ASSIGN, OP_RESET_BIT, OP_SET_BIT, OP_NEGATE, OP_FORCE_HIGH,
      OP_FORCE_LOW, OP_COPY_BINARY, OP_FALL_EDGE, OP_RISE_EDGE,
      OP_CMP_EQ, OP_CMP_NE, OP_CMP_GT, OP_CMP_LT, OP_CMP_GE, OP_CMP_LE,
      OP_OPEN_AND, OP_OPEN_ANDN, OP_OPEN_OR, OP_OPEN_ORN, OP_OPEN_XOR,
      OP_OPEN_XORN, OP_CLOSE
   } blr_op_type;

   // Function code kept in a nesting entry
   typedef enum logic [2:0] {
      FN_AND, FN_ANDN, FN_OR, FN_ORN, FN_XOR, FN_XORN
   } blr_nest_fn_type;

   // Status word, bit 8 down to bit 0
   typedef struct packed {
      logic binary_result_bit;
      logic condition_code_high;
      logic condition_code_low;
      logic arith_flow_error;
      logic sticky_flow_error;
      logic or_pending_bit;
      logic operand_level_bit;
      logic logic_result_bit;
      logic first_check_bit;
   } blr_status_type;

   // One nesting stack entry
   typedef struct packed {
      logic saved_result;
      logic saved_or;
      blr_nest_fn_type fn_code;
   } blr_nest_type;

endpackage

//--- hdl/blr_nest_stack.sv
`timescale 1ns/1ps
module blr_nest_stack (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic reset,
   // Push and pop requests
   input wire logic push,
   input wire logic pop,
   input wire blr_pkg::blr_nest_type push_entry,
   // Stack state
   output blr_pkg::blr_nest_type top_entry,
   output logic [blr_pkg::DEPTH_W-1:0] depth,
   output logic full,
   output logic empty
);

   blr_pkg::blr_nest_type mem_reg [blr_pkg::STACK_DEPTH];
   blr_pkg::blr_nest_type mem_next [blr_pkg::STACK_DEPTH];
   logic [blr_pkg::DEPTH_W-1:0] depth_reg;
   logic [blr_pkg::DEPTH_W-1:0] depth_next;

   // Push onto a free slot, pop from a filled one; push wins, and the stack ignores requests at full or empty
   always_comb begin
      mem_next = mem_reg;
      depth_next = depth_reg;
      if (push && !full) begin
         mem_next[depth_reg] = push_entry;
         depth_next = depth_reg + 3'h1;
      end else if (pop && !empty) begin
         depth_next = depth_reg - 3'h1;
      end
   end

   // Register stack state
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         depth_reg <= '0;
         for (int i = 0; i < blr_pkg::STACK_DEPTH; i++) begin
            mem_reg[i] <= '0;
         end
      end else begin
         depth_reg <= depth_next;
         mem_reg <= mem_next;
      end
   end

   // Status outputs
   assign depth = depth_reg;
   assign full = (depth_reg == 3'(blr_pkg::STACK_DEPTH));
   assign empty = (depth_reg == 3'h0);
   assign top_entry = empty ? '0 : mem_reg[depth_reg - 3'h1];

endmodule // blr_nest_stack

//--- hdl/blr_unit.sv
// The placing of the registers and the Avalon-MM register port were left to the implementer.
`timescale 1ns/1ps
// How it works
// - Assign writes result when gate open
// - Assign writes zero when gate closed
// - Reset bit only when result and gate
// - Set bit only when result and gate
// - Negate inverts result, operand level high
// - Force high: result, level one; clear or, check
// - Force low clears result, level, or, check
// - Copy result to binary bit only
// - Edge ops compare, then store flag
// - Falling edge: previous one, current zero
// - Rising edge: previous zero, current one
// - Compare sets result from relation
// - Compare encodes less, equal, greater codes
// - Signed 16-bit compare, six relations
// - Close pops, restores or, combines result
// - Nesting stack holds seven entries
// - Compare clears overflow, or; sets check
module blr_unit (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic reset,
   // Avalon-MM slave
   input wire logic [4:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // Bit memory port
   output logic [2:0] bit_area,
   output logic [15:0] bit_index,
   output logic bit_rd_en,
   input wire logic bit_rd_data,
   output logic bit_wr_en,
   output logic bit_wr_data,
   // Observed state
   output blr_pkg::blr_status_type status_word,
   output logic busy
);

   typedef enum logic [1:0] {ST_IDLE, ST_FETCH, ST_EXEC} blr_state_type;

   blr_state_type st_reg, st_next;
   blr_pkg::blr_status_type stat_reg, stat_next;
   logic [31:0] cmd_reg, cmd_next;
   logic [15:0] acc_one_reg, acc_one_next;
   logic [15:0] acc_two_reg, acc_two_next;
   logic gate_reg, gate_next;
   logic ovf_reg, ovf_next;
   logic unf_reg, unf_next;
   logic [31:0] rdata_reg, rdata_next;
   logic rd_ack_reg, rd_ack_next;
   logic rd_en_reg, rd_en_next;
   logic wr_en_reg, wr_en_next;
   logic wr_data_reg, wr_data_next;
   logic push, pop;
   blr_pkg::blr_nest_type push_entry, top_entry;
   logic [2:0] depth;
   logic full, empty;
   blr_pkg::blr_op_type op;
   logic take_wr, take_rd, gt, eq, lt, res, cmp_res;

   // Byte-lane merge of a bus write into an old register word
   function automatic logic [31:0] merge(input logic [31:0] old_w, input logic [31:0] new_w,
                                         input logic [3:0] be);
      logic [31:0] m;
      m = old_w;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) m[8*i +: 8] = new_w[8*i +: 8];
      end
      return m;
   endfunction

   // Selected relation of accumulator two against accumulator one
   function automatic logic relation(input blr_pkg::blr_op_type code, input logic g,
                                     input logic e);
      logic r;
      r = 1'b0;
      unique case (code)
         blr_pkg::OP_CMP_EQ: r = e;
         blr_pkg::OP_CMP_NE: r = !e;
         blr_pkg::OP_CMP_GT: r = g;
         blr_pkg::OP_CMP_LT: r = !g && !e;
         blr_pkg::OP_CMP_GE: r = g || e;
         blr_pkg::OP_CMP_LE: r = !g;
         default: r = 1'b0;
      endcase
      return r;
   endfunction

   // Combine a saved nesting entry with the current result
   function automatic logic combine(input blr_pkg::blr_nest_type ent, input logic cur);
      logic r;
      unique case (ent.fn_code)
         blr_pkg::FN_AND: r = ent.saved_or | (ent.saved_result & cur);
         blr_pkg::FN_ANDN: r = ent.saved_or | (ent.saved_result & !cur);
         blr_pkg::FN_OR: r = ent.saved_result | cur;
         blr_pkg::FN_ORN: r = ent.saved_result | !cur;
         blr_pkg::FN_XOR: r = ent.saved_result ^ cur;
         blr_pkg::FN_XORN: r = ent.saved_result ^ !cur;
         default: r = 1'b0;
      endcase
      return r;
   endfunction

   // Nesting stack of saved results
   blr_nest_stack u_stack (
      .ref_clk(ref_clk),
      .reset(reset),
      .push(push),
      .pop(pop),
      .push_entry(push_entry),
      .top_entry(top_entry),
      .depth(depth),
      .full(full),
      .empty(empty)
   );

   // Decoded command and compare flags
   assign op = blr_pkg::blr_op_type'(cmd_reg[blr_pkg::CMD_OP_LSB +: blr_pkg::CMD_OP_W]);
   assign gt = $signed(acc_two_reg) > $signed(acc_one_reg);
   assign eq = (acc_two_reg == acc_one_reg);
   assign lt = !gt && !eq;
   assign cmp_res = relation(op, gt, eq);
   assign take_wr = avs_write && (st_reg == ST_IDLE);
   assign take_rd = avs_read && !rd_ack_reg;

   // Bus slave, command start and instruction execution
   always_comb begin
      st_next = st_reg;
      stat_next = stat_reg;
      cmd_next = cmd_reg;
      acc_one_next = acc_one_reg;
      acc_two_next = acc_two_reg;
      gate_next = gate_reg;
      ovf_next = ovf_reg;
      unf_next = unf_reg;
      rdata_next = rdata_reg;
      rd_ack_next = take_rd;
      rd_en_next = 1'b0;
      wr_en_next = 1'b0;
      wr_data_next = wr_data_reg;
      push = 1'b0;
      pop = 1'b0;
      push_entry = '0;
      res = 1'b0;
      // Register read, one wait cycle
      if (take_rd) begin
         unique case (avs_address)
            blr_pkg::REG_CMD: rdata_next = {cmd_reg[31:1], (st_reg != ST_IDLE)};
            blr_pkg::REG_STATUS: rdata_next = {6'h00, unf_reg, ovf_reg, 5'h00, depth,
                                               7'h00, stat_reg};
            blr_pkg::REG_ACC_ONE: rdata_next = {16'h0000, acc_one_reg};
            blr_pkg::REG_ACC_TWO: rdata_next = {16'h0000, acc_two_reg};
            blr_pkg::REG_CTRL: rdata_next = {31'h0000_0000, gate_reg};
            default: rdata_next = 32'h0000_0000;
         endcase
      end
      // Register write, only while idle
      if (take_wr) begin
         unique case (avs_address)
            blr_pkg::REG_CMD: begin
               cmd_next = merge(cmd_reg, avs_writedata, avs_byteenable);
               if (cmd_next[4:0] == 5'(blr_pkg::OP_FALL_EDGE) ||
                   cmd_next[4:0] == 5'(blr_pkg::OP_RISE_EDGE)) begin
                  st_next = ST_FETCH;
                  rd_en_next = 1'b1;
               end else begin
                  st_next = ST_EXEC;
               end
            end
            blr_pkg::REG_STATUS: begin
               if (avs_byteenable[0]) stat_next[7:0] = avs_writedata[7:0];
               if (avs_byteenable[1]) stat_next[8] = avs_writedata[8];
               if (avs_byteenable[3] && avs_writedata[blr_pkg::STAT_OVF_BIT]) ovf_next = 1'b0;
               if (avs_byteenable[3] && avs_writedata[blr_pkg::STAT_UNF_BIT]) unf_next = 1'b0;
            end
            blr_pkg::REG_ACC_ONE: begin
               acc_one_next = 16'(merge({16'h0000, acc_one_reg}, avs_writedata, avs_byteenable));
            end
            blr_pkg::REG_ACC_TWO: begin
               acc_two_next = 16'(merge({16'h0000, acc_two_reg}, avs_writedata, avs_byteenable));
            end
            blr_pkg::REG_CTRL: begin
               if (avs_byteenable[0]) gate_next = avs_writedata[blr_pkg::CTRL_GATE_BIT];
            end
            default: begin
            end
         endcase
      end
      // Execution state machine
      unique case (st_reg)
         ST_IDLE: begin
         end
         ST_FETCH: st_next = ST_EXEC;
         ST_EXEC: begin
            st_next = ST_IDLE;
            unique case (op)
               blr_pkg::OP_ASSIGN: begin
                  wr_en_next = 1'b1;
                  wr_data_next = stat_reg.logic_result_bit & gate_reg;
                  stat_next.or_pending_bit = 1'b0;
                  stat_next.operand_level_bit = wr_data_next;
                  stat_next.first_check_bit = 1'b0;
               end
               blr_pkg::OP_RESET_BIT, blr_pkg::OP_SET_BIT: begin
                  wr_en_next = stat_reg.logic_result_bit & gate_reg;
                  wr_data_next = (op == blr_pkg::OP_SET_BIT);
                  stat_next.or_pending_bit = 1'b0;
                  stat_next.operand_level_bit = stat_reg.logic_result_bit;
                  stat_next.first_check_bit = 1'b0;
               end
               blr_pkg::OP_NEGATE: begin
                  stat_next.logic_result_bit = !stat_reg.logic_result_bit;
                  stat_next.operand_level_bit = 1'b1;
               end
               blr_pkg::OP_FORCE_HIGH: begin
                  stat_next.logic_result_bit = 1'b1;
                  stat_next.operand_level_bit = 1'b1;
                  stat_next.or_pending_bit = 1'b0;
                  stat_next.first_check_bit = 1'b0;
               end
               blr_pkg::OP_FORCE_LOW: begin
                  stat_next.logic_result_bit = 1'b0;
                  stat_next.operand_level_bit = 1'b0;
                  stat_next.or_pending_bit = 1'b0;
                  stat_next.first_check_bit = 1'b0;
               end
               blr_pkg::OP_COPY_BINARY: begin
                  stat_next.binary_result_bit = stat_reg.logic_result_bit;
               end
               blr_pkg::OP_FALL_EDGE, blr_pkg::OP_RISE_EDGE: begin
                  wr_en_next = 1'b1;
                  wr_data_next = stat_reg.logic_result_bit;
                  if (op == blr_pkg::OP_FALL_EDGE) begin
                     res = bit_rd_data & !stat_reg.logic_result_bit;
                  end else begin
                     res = !bit_rd_data & stat_reg.logic_result_bit;
                  end
                  stat_next.logic_result_bit = res;
                  stat_next.operand_level_bit = res;
                  stat_next.or_pending_bit = 1'b0;
                  stat_next.first_check_bit = 1'b1;
               end
               blr_pkg::OP_CMP_EQ, blr_pkg::OP_CMP_NE, blr_pkg::OP_CMP_GT,
               blr_pkg::OP_CMP_LT, blr_pkg::OP_CMP_GE, blr_pkg::OP_CMP_LE: begin
                  stat_next.logic_result_bit = cmp_res;
                  stat_next.operand_level_bit = cmp_res;
                  stat_next.condition_code_high = gt;
                  stat_next.condition_code_low = lt;
                  stat_next.arith_flow_error = 1'b0;
                  stat_next.or_pending_bit = 1'b0;
                  stat_next.first_check_bit = 1'b1;
               end
               blr_pkg::OP_OPEN_AND, blr_pkg::OP_OPEN_ANDN, blr_pkg::OP_OPEN_OR,
               blr_pkg::OP_OPEN_ORN, blr_pkg::OP_OPEN_XOR, blr_pkg::OP_OPEN_XORN: begin
                  if (full) begin
                     ovf_next = 1'b1;
                  end else begin
                     push = 1'b1;
                     push_entry.saved_result = stat_reg.logic_result_bit;
                     push_entry.saved_or = stat_reg.or_pending_bit;
                     push_entry.fn_code = blr_pkg::blr_nest_fn_type'(3'(op - 5'(blr_pkg::OP_OPEN_AND)));
                  end
                  stat_next.or_pending_bit = 1'b0;
                  stat_next.operand_level_bit = 1'b1;
                  stat_next.first_check_bit = 1'b0;
               end
               blr_pkg::OP_CLOSE: begin
                  if (empty) begin
                     unf_next = 1'b1;
                  end else begin
                     pop = 1'b1;
                     stat_next.logic_result_bit = combine(top_entry,
                                                          stat_reg.logic_result_bit);
                     stat_next.or_pending_bit = top_entry.saved_or;
                  end
                  stat_next.operand_level_bit = 1'b1;
                  stat_next.first_check_bit = 1'b1;
               end
               default: begin
               end
            endcase
         end
         default: st_next = ST_IDLE;
      endcase
      // A fault flag raised by execution wins over a software clear
      if (st_reg == ST_EXEC && full && push_entry == '0 && op >= blr_pkg::OP_OPEN_AND &&
          op <= blr_pkg::OP_OPEN_XORN) ovf_next = 1'b1;
   end

   // Register all state
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         st_reg <= ST_IDLE;
         stat_reg <= blr_pkg::STATUS_RESET;
         cmd_reg <= blr_pkg::CMD_RESET;
         acc_one_reg <= blr_pkg::ACC_RESET;
         acc_two_reg <= blr_pkg::ACC_RESET;
         gate_reg <= blr_pkg::GATE_RESET;
         ovf_reg <= 1'b0;
         unf_reg <= 1'b0;
         rdata_reg <= 32'h0000_0000;
         rd_ack_reg <= 1'b0;
         rd_en_reg <= 1'b0;
         wr_en_reg <= 1'b0;
         wr_data_reg <= 1'b0;
      end else begin
         st_reg <= st_next;
         stat_reg <= stat_next;
         cmd_reg <= cmd_next;
         acc_one_reg <= acc_one_next;
         acc_two_reg <= acc_two_next;
         gate_reg <= gate_next;
         ovf_reg <= ovf_next;
         unf_reg <= unf_next;
         rdata_reg <= rdata_next;
         rd_ack_reg <= rd_ack_next;
         rd_en_reg <= rd_en_next;
         wr_en_reg <= wr_en_next;
         wr_data_reg <= wr_data_next;
      end
   end

   // Outputs
   assign avs_readdata = rdata_reg;
   assign avs_waitrequest = (avs_read && !rd_ack_reg) || (avs_write && st_reg != ST_IDLE);
   assign bit_area = cmd_reg[blr_pkg::CMD_AREA_LSB +: blr_pkg::CMD_AREA_W];
   assign bit_index = cmd_reg[blr_pkg::CMD_INDEX_LSB +: blr_pkg::CMD_INDEX_W];
   assign bit_rd_en = rd_en_reg;
   assign bit_wr_en = wr_en_reg;
   assign bit_wr_data = wr_data_reg;
   assign status_word = stat_reg;
   assign busy = (st_reg != ST_IDLE);

endmodule // blr_unit

//--- tb/blr_unit_sva.sv
`timescale 1ns/1ps
module blr_unit_sva (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic reset,
   // Register bus
   input wire logic [4:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   // Bit memory port
   input wire logic [2:0] bit_area,
   input wire logic [15:0] bit_index,
   input wire logic bit_rd_en,
   input wire logic bit_rd_data,
   input wire logic bit_wr_en,
   input wire logic bit_wr_data,
   // Observed state
   input wire blr_pkg::blr_status_type status_word,
   input wire logic busy
);
   // Command write taken by the unit, and its op code
   logic cmd_go;
   logic [4:0] op;
   assign cmd_go = avs_write && !avs_waitrequest && avs_address == blr_pkg::REG_CMD
      && avs_byteenable[0];
   assign op = avs_writedata[4:0];

   // Compare outcome from op code and the greater and less codes
   function automatic logic rel(input logic [4:0] o, input logic g, input logic l);
      case (o)
         5'h0A: return !g && !l;
         5'h0B: return g || l;
         5'h0C: return g;
         5'h0D: return l;
         5'h0E: return !l;
         default: return !g;
      endcase
   endfunction

   default clocking @(posedge ref_clk); endclocking
   default disable iff (reset);

   a_assign_write: assert property (cmd_go && op == 5'h01 |=> ##1 bit_wr_en
      && (!bit_wr_data || $past(status_word[1], 2)) && status_word[3] == 1'b0
      && status_word[0] == 1'b0) else $error("assign write or status wrong");
   a_negate_flip: assert property (cmd_go && op == 5'h04 |=> ##1 status_word[3:0] ==
      {$past(status_word[3], 2), 1'b1, !$past(status_word[1], 2), $past(status_word[0], 2)})
      else $error("negate status wrong");
   a_force_high: assert property (cmd_go && op == 5'h05 |=> ##1 status_word[3:0] == 4'h6
      && status_word[8:4] == $past(status_word[8:4], 2)) else $error("force high wrong");
   a_force_low: assert property (cmd_go && op == 5'h06 |=> ##1 status_word[3:0] == 4'h0)
      else $error("force low wrong");
   a_copy_binary: assert property (cmd_go && op == 5'h07 |=> ##1 status_word ==
      {$past(status_word[1], 2), $past(status_word[7:0], 2)}) else $error("copy wrong");
   a_edge_store: assert property (bit_rd_en |-> ##2 bit_wr_en
      && bit_wr_data == $past(status_word[1], 2) && !status_word[3] && status_word[0])
      else $error("edge flag store wrong");
   a_cmp_codes: assert property (cmd_go && op inside {[5'h0A:5'h0F]} |=> ##1
      !(status_word[7] && status_word[6]) && status_word[0]
      && status_word[5:3] == {1'b0, $past(status_word[4], 2), 1'b0})
      else $error("compare codes wrong");
   a_cmp_relation: assert property (cmd_go && op inside {[5'h0A:5'h0F]} |=> ##1
      status_word[1] == rel($past(op, 2), status_word[7], status_word[6]))
      else $error("compare result wrong");
endmodule // blr_unit_sva

bind blr_unit blr_unit_sva u_sva (.ref_clk(ref_clk), .reset(reset),
   .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
   .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
   .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .bit_area(bit_area),
   .bit_index(bit_index), .bit_rd_en(bit_rd_en), .bit_rd_data(bit_rd_data),
   .bit_wr_en(bit_wr_en), .bit_wr_data(bit_wr_data), .status_word(status_word), .busy(busy));

//--- tb/blr_unit_tb.sv
`timescale 1ns/1ps
module blr_unit_tb;
   typedef struct packed {
      logic [4:0] op;
      logic [2:0] ar;
      logic [3:0] ix;
      logic [8:0] st;
      logic m;
   } blr_step_type;
   logic ref_clk, reset, avs_read, avs_write, avs_waitrequest, busy;
   logic [4:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata, rd;
   logic [3:0] avs_byteenable;
   logic [2:0] bit_area;
   logic [15:0] bit_index;
   logic bit_rd_en, bit_rd_data, bit_wr_en, bit_wr_data;
   blr_pkg::blr_status_type status_word;
   logic bmem [0:7][0:15];
   int n_fail, num_checks;
   logic [4:0] ra [5] = '{5'h04, 5'h08, 5'h0C, 5'h10, 5'h14};
   logic [31:0] rv [5] = '{32'h0, 32'h0, 32'h0, 32'h1, 32'h0};
   logic [15:0] cv2 [3] = '{16'h0005, 16'hFFFE, 16'h8001};
   logic [15:0] cv1 [3] = '{16'h0003, 16'h0001, 16'h8001};
   // Op, area, index, expected status, expected bit at area and index
   blr_step_type steps [31] = '{
      '{5'h05, 3'h0, 4'hF, 9'h006, 1'b0}, '{5'h01, 3'h2, 4'h3, 9'h006, 1'b1},
      '{5'h06, 3'h0, 4'hF, 9'h000, 1'b0}, '{5'h01, 3'h2, 4'h3, 9'h000, 1'b0},
      '{5'h05, 3'h0, 4'hF, 9'h006, 1'b0}, '{5'h07, 3'h0, 4'hF, 9'h106, 1'b0},
      '{5'h06, 3'h0, 4'hF, 9'h100, 1'b0}, '{5'h04, 3'h0, 4'hF, 9'h106, 1'b0},
      '{5'h03, 3'h2, 4'h5, 9'h106, 1'b1}, '{5'h06, 3'h0, 4'hF, 9'h100, 1'b0},
      '{5'h02, 3'h2, 4'h5, 9'h100, 1'b1}, '{5'h05, 3'h0, 4'hF, 9'h106, 1'b0},
      '{5'h02, 3'h2, 4'h5, 9'h106, 1'b0}, '{5'h09, 3'h3, 4'h0, 9'h107, 1'b1},
      '{5'h05, 3'h0, 4'hF, 9'h106, 1'b0}, '{5'h09, 3'h3, 4'h0, 9'h101, 1'b1},
      '{5'h06, 3'h0, 4'hF, 9'h100, 1'b0}, '{5'h08, 3'h3, 4'h0, 9'h107, 1'b0},
      '{5'h06, 3'h0, 4'hF, 9'h100, 1'b0}, '{5'h08, 3'h3, 4'h0, 9'h101, 1'b0},
      '{5'h05, 3'h0, 4'hF, 9'h106, 1'b0}, '{5'h10, 3'h0, 4'hF, 9'h106, 1'b0},
      '{5'h06, 3'h0, 4'hF, 9'h100, 1'b0}, '{5'h16, 3'h0, 4'hF, 9'h105, 1'b0},
      '{5'h05, 3'h0, 4'hF, 9'h106, 1'b0}, '{5'h01, 3'h2, 4'h6, 9'h102, 1'b0},
      '{5'h03, 3'h2, 4'h7, 9'h106, 1'b0}, '{5'h02, 3'h2, 4'h8, 9'h106, 1'b1},
      '{5'h12, 3'h0, 4'hF, 9'h106, 1'b0}, '{5'h06, 3'h0, 4'hF, 9'h100, 1'b0},
      '{5'h16, 3'h0, 4'hF, 9'h107, 1'b0}};

   // Unit under test
   blr_unit DUT (.ref_clk(ref_clk), .reset(reset), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .bit_area(bit_area), .bit_index(bit_index),
      .bit_rd_en(bit_rd_en), .bit_rd_data(bit_rd_data), .bit_wr_en(bit_wr_en),
      .bit_wr_data(bit_wr_data), .status_word(status_word), .busy(busy));

   // Clock
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   // Bit memory, read data one cycle after the read pulse
   always @(posedge ref_clk) begin
      if (reset) begin
         bit_rd_data <= 1'b0;
         foreach (bmem[i, j]) bmem[i][j] <= (i == 2 && (j == 6 || j == 8));
      end else begin
         if (bit_rd_en) bit_rd_data <= bmem[bit_area][bit_index[3:0]];
         if (bit_wr_en) bmem[bit_area][bit_index[3:0]] <= bit_wr_data;
      end
   end

   // Compare and count
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask

   // Hold the request until waitrequest is seen low at an edge
   task automatic wait_ack();
      int n;
      n = 0;
      do begin
         @(posedge ref_clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 50);
      if (n >= 50) chk("waitrequest", 32'h0, 32'h1);
   endtask

   task automatic av_wr(input logic [4:0] a, input logic [31:0] d, input logic [3:0] be);
      @(posedge ref_clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_byteenable <= be;
      avs_write <= 1'b1;
      wait_ack();
      avs_write <= 1'b0;
   endtask

   task automatic av_rd(input logic [4:0] a);
      @(posedge ref_clk);
      avs_address <= a;
      avs_read <= 1'b1;
      wait_ack();
      rd = avs_readdata;
      avs_read <= 1'b0;
   endtask

   // Wait for a command to finish and its bit write to land
   task automatic wait_idle();
      int n;
      n = 0;
      do begin
         @(posedge ref_clk);
         #1;
         n++;
      end while (busy !== 1'b0 && n < 20);
      @(posedge ref_clk);
      #1;
      if (n >= 20) chk("busy", 32'h0, 32'h1);
   endtask

   task automatic exec(input logic [4:0] op, input logic [2:0] ar = 3'h0,
         input logic [3:0] ix = 4'hF);
      av_wr(blr_pkg::REG_CMD, {12'h000, ix, 5'h00, ar, 3'h0, op}, 4'hF);
      wait_idle();
   endtask

   task automatic conclude();
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   // Watchdog
   initial begin
      repeat (10000) @(posedge ref_clk);
      n_fail++;
      conclude();
   end

   // Test sequence
   initial begin
      logic g, l, r;
      reset = 1'b1;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_address = 5'h00;
      avs_writedata = 32'h0;
      avs_byteenable = 4'h0;
      n_fail = 0;
      num_checks = 0;
      repeat (20) @(posedge ref_clk);
      reset <= 1'b0;
      av_wr(5'h14, 32'hFFFF_FFFF, 4'hF);
      for (int i = 0; i < 5; i++) begin
         av_rd(ra[i]);
         chk("register after reset", rv[i], rd);
      end
      $display("test reset values done");
      for (int i = 0; i < 31; i++) begin
         if (i == 24) av_wr(blr_pkg::REG_CTRL, 32'h0, 4'hF);
         exec(steps[i].op, steps[i].ar, steps[i].ix);
         chk("status", {23'h0, steps[i].st}, {23'h0, status_word});
         chk("bit", {31'h0, steps[i].m}, {31'h0, bmem[steps[i].ar][steps[i].ix]});
      end
      av_wr(blr_pkg::REG_CTRL, 32'h1, 4'hF);
      $display("test bit operations done");
      for (int i = 0; i < 3; i++) begin
         av_wr(blr_pkg::REG_ACC_TWO, {16'h0, cv2[i]}, 4'hF);
         av_wr(blr_pkg::REG_ACC_ONE, {16'h0, cv1[i]}, 4'hF);
         g = (i == 0);
         l = (i == 1);
         for (int k = 0; k < 6; k++) begin
            r = (k == 0) ? !g && !l : (k == 1) ? g || l : (k == 2) ? g : (k == 3) ? l
               : (k == 4) ? !l : !g;
            exec(5'h0A + 5'(k));
            chk("compare", {23'h0, 1'b1, g, l, 3'h0, r, r, 1'b1}, {23'h0, status_word});
         end
      end
      $display("test compares done");
      // Edge op keeps the unit busy long enough for the negate to be stalled
      av_wr(blr_pkg::REG_CMD, 32'h0000_0009, 4'hF);
      av_wr(blr_pkg::REG_CMD, 32'h0000_0004, 4'hF);
      wait_idle();
      chk("stalled command", 32'h105, {23'h0, status_word});
      for (int i = 0; i < 8; i++) exec(5'h10);
      av_rd(blr_pkg::REG_STATUS);
      chk("stack full", 32'h0107_0000, rd & 32'h0307_0000);
      for (int i = 0; i < 8; i++) exec(5'h16);
      av_rd(blr_pkg::REG_STATUS);
      chk("stack empty", 32'h0300_0000, rd & 32'h0307_0000);
      av_wr(blr_pkg::REG_STATUS, 32'h0300_0000, 4'h8);
      av_rd(blr_pkg::REG_STATUS);
      chk("flags cleared", 32'h0, rd & 32'h0307_0000);
      av_rd(blr_pkg::REG_CMD);
      chk("command readback", 32'h000F_0016, rd);
      $display("test nesting done");
      conclude();
   end
endmodule // blr_unit_tb
